// >>> verilog/fasu_pkg.sv
// Shared types and constants of the float/fixed add-subtract datapath
package fasu_pkg;

    localparam int FASU_MW = 16;
    localparam int FASU_EW = 4;
    localparam int FASU_XW = 12;
    localparam logic signed [5:0] FASU_EXP_MIN = 6'h38;
    localparam logic signed [5:0] FASU_EXP_MAX = 6'h07;
    localparam logic [15:0] FASU_MANT_POS = 16'h7fff;
    localparam logic [15:0] FASU_MANT_NEG = 16'h8000;
    localparam logic [15:0] FASU_UNS_MAX = 16'hffff;
    localparam logic [15:0] FASU_UNS_MIN = 16'h0000;
    localparam logic [4:0] FASU_SHIFT_FULL = 5'h10;

    // Operations the decoder can ask for
    typedef enum logic [1:0] {
        FASU_OP_ADD = 2'h0,
        FASU_OP_SUB = 2'h1,
        FASU_OP_FIX2FLT = 2'h3,
        FASU_OP_FLT2FIX = 2'h2
    } fasu_op_t;

    // Accumulator word, mantissa above exponent
    typedef struct packed {
        logic [15:0] mant;
        logic [3:0] expo;
    } fasu_word_t;

    localparam fasu_word_t FASU_WORD_RST = 20'h0_0000;

    typedef struct packed {
        logic carry;
        logic neg;
        logic zero;
    } fasu_flags_t;

    localparam fasu_flags_t FASU_FLAGS_RST = 3'h0;

    // One adder instruction from the decoder
    typedef struct packed {
        logic go;
        fasu_op_t op;
        logic flt;
        logic uns;
        logic dst;
        fasu_word_t opa;
        fasu_word_t opb;
    } fasu_alu_req_t;

    // One multiply from the decoder
    typedef struct packed {
        logic go;
        logic flt;
        logic [11:0] x;
        logic [11:0] y;
        logic [3:0] ex;
        logic [3:0] ey;
    } fasu_mul_req_t;

    typedef struct packed {
        fasu_word_t acc_a;
        fasu_word_t acc_b;
        fasu_flags_t flags;
        fasu_word_t mul;
    } fasu_state_t;

    localparam fasu_state_t FASU_STATE_RST = {FASU_WORD_RST, FASU_WORD_RST, FASU_FLAGS_RST, FASU_WORD_RST};

endpackage

// >>> verilog/fasu_unit.sv
// Float/fixed add-subtract datapath with accumulator pair and multiplier format stage
`timescale 1ns/1ps
module fasu_unit (
    input logic core_clk,
    input logic arst_n,
    input logic clk_en,
    input logic overflow_saturate_enable,
    input fasu_pkg::fasu_alu_req_t alu_req,
    input fasu_pkg::fasu_mul_req_t mul_req,
    output fasu_pkg::fasu_word_t acc_a,
    output fasu_pkg::fasu_word_t acc_b,
    output fasu_pkg::fasu_flags_t condition_flags,
    output fasu_pkg::fasu_word_t mul_out
);
    import fasu_pkg::*;

    fasu_state_t state_ff;
    fasu_state_t nxt_state;

    // Sign-extend a 4-bit exponent for range checks
    function automatic logic signed [5:0] fasu_sext(input logic [3:0] e);
        fasu_sext = $signed({{2{e[3]}}, e});
    endfunction

    // Arithmetic right shift; far shifts leave only the sign
    function automatic logic [15:0] fasu_shr(input logic [15:0] m, input logic [4:0] d);
        if (d >= FASU_SHIFT_FULL) begin
            fasu_shr = {16{m[15]}};
        end else begin
            fasu_shr = 16'($signed(m) >>> d);
        end
    endfunction

    // Normalize a 17-bit sum at exponent e, with both exponent protections
    function automatic fasu_word_t fasu_norm(input logic [16:0] s, input logic signed [5:0] e);
        logic [15:0] m;
        logic signed [5:0] c;
        logic signed [5:0] lzs;
        logic [4:0] lz;
        logic [4:0] sh;
        fasu_word_t w;
        m = s[15:0];
        c = e;
        lz = 5'h0f;
        sh = 5'h00;
        lzs = 6'sh00;
        if (s[16] != s[15]) begin
            // Carry into the sign: one step right, exponent up
            m = s[16:1];
            c = 6'(e + 6'sh01);
        end else begin
            for (int i = 14; i >= 0; i--) begin
                if (m[i] != m[15] && lz == 5'h0f) begin
                    lz = 5'(14 - i);
                end
            end
            lzs = $signed({1'b0, lz});
            if (6'(e - lzs) < FASU_EXP_MIN) begin
                // Below range: keep minimum exponent, shift only as far as it allows
                sh = 5'(e - FASU_EXP_MIN);
                c = FASU_EXP_MIN;
            end else begin
                sh = lz;
                c = 6'(e - lzs);
            end
            m = m << sh;
        end
        if (c > FASU_EXP_MAX) begin
            m = s[16] ? FASU_MANT_NEG : FASU_MANT_POS;
            c = FASU_EXP_MAX;
        end
        w.mant = m;
        w.expo = c[3:0];
        fasu_norm = w;
    endfunction

    // Working values of the adder, conversion and multiplier paths
    logic signed [5:0] ea;
    logic signed [5:0] eb;
    logic signed [5:0] emax;
    logic [4:0] diff;
    logic [15:0] ma;
    logic [15:0] mb;
    logic cin;
    logic [16:0] ssum;
    logic [16:0] usum;
    logic sub;
    logic sovf;
    logic uovf;
    logic signed [5:0] scale;
    logic [4:0] lsh;
    logic [31:0] wide;
    logic signed [23:0] prod;
    logic signed [5:0] esum;
    fasu_word_t res;

    // Adder, conversion and multiplier datapath feeding the next state
    always_comb begin
        nxt_state = state_ff;
        res = state_ff.acc_a;
        sub = (alu_req.op == FASU_OP_SUB);
        ea = fasu_sext(alu_req.opa.expo);
        eb = fasu_sext(alu_req.opb.expo);
        emax = ea;
        diff = 5'h00;
        ma = alu_req.opa.mant;
        mb = sub ? ~alu_req.opb.mant : alu_req.opb.mant;
        cin = 1'b0;
        ssum = 17'h0_0000;
        usum = 17'h0_0000;
        sovf = 1'b0;
        uovf = 1'b0;
        scale = fasu_sext(alu_req.opb.mant[3:0]);
        lsh = 5'h00;
        wide = 32'h0000_0000;
        prod = 24'sh00_0000;
        esum = 6'sh00;
        if (alu_req.go) begin
            unique case (alu_req.op)
                FASU_OP_ADD, FASU_OP_SUB: begin
                    if (alu_req.flt) begin
                        // Completing increment only when minuend exponent is not larger
                        cin = sub && (ea <= eb);
                        if (ea >= eb) begin
                            emax = ea;
                            diff = 5'(ea - eb);
                            mb = fasu_shr(mb, diff);
                        end else begin
                            emax = eb;
                            diff = 5'(eb - ea);
                            ma = fasu_shr(ma, diff);
                        end
                        // Sign-extended fractions keep the carry into the sign visible
                        ssum = 17'({ma[15], ma} + {mb[15], mb} + {16'h0000, cin});
                        usum = 17'({1'b0, ma} + {1'b0, mb} + {16'h0000, cin});
                        res = fasu_norm(ssum, emax);
                    end else begin
                        cin = sub;
                        usum = 17'({1'b0, ma} + {1'b0, mb} + {16'h0000, cin});
                        res.mant = usum[15:0];
                        res.expo = 4'h0;
                        sovf = (ma[15] == mb[15]) && (usum[15] != ma[15]);
                        uovf = sub ? !usum[16] : usum[16];
                        // Saturation is optional so wraparound code keeps working
                        if (overflow_saturate_enable) begin
                            if (alu_req.uns && uovf) begin
                                res.mant = sub ? FASU_UNS_MIN : FASU_UNS_MAX;
                            end else if (!alu_req.uns && sovf) begin
                                res.mant = ma[15] ? FASU_MANT_NEG : FASU_MANT_POS;
                            end
                        end
                    end
                end
                FASU_OP_FIX2FLT: begin
                    res = fasu_norm({ma[15], ma}, scale);
                end
                FASU_OP_FLT2FIX: begin
                    res.expo = 4'h0;
                    if (scale >= ea) begin
                        res.mant = fasu_shr(ma, 5'(scale - ea));
                    end else begin
                        lsh = 5'(ea - scale);
                        wide = 32'($signed(ma)) << lsh;
                        // Bits shifted past the sign must all match it
                        if (wide[31:15] != {17{wide[31]}}) begin
                            res.mant = ma[15] ? FASU_MANT_NEG : FASU_MANT_POS;
                        end else begin
                            res.mant = wide[15:0];
                        end
                    end
                end
            endcase
            if (alu_req.dst) begin
                nxt_state.acc_b = res;
            end else begin
                nxt_state.acc_a = res;
            end
            nxt_state.flags.carry = usum[16];
            nxt_state.flags.neg = res.mant[15];
            nxt_state.flags.zero = (res.mant == 16'h0000);
        end
        // Multiplier keeps the upper product bits; the low seven bits of the full product are dropped
        if (mul_req.go) begin
            prod = $signed(mul_req.x) * $signed(mul_req.y);
            nxt_state.mul.mant = prod[22:7];
            nxt_state.mul.expo = 4'h0;
            if (mul_req.flt) begin
                esum = 6'(fasu_sext(mul_req.ex) + fasu_sext(mul_req.ey));
                if (esum > FASU_EXP_MAX) begin
                    nxt_state.mul.expo = FASU_EXP_MAX[3:0];
                end else if (esum < FASU_EXP_MIN) begin
                    nxt_state.mul.expo = FASU_EXP_MIN[3:0];
                end else begin
                    nxt_state.mul.expo = esum[3:0];
                end
            end
        end
    end

    // Whole state registered at the end of the instruction cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= FASU_STATE_RST;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    assign acc_a = state_ff.acc_a;
    assign acc_b = state_ff.acc_b;
    assign condition_flags = state_ff.flags;
    assign mul_out = state_ff.mul;

endmodule

// >>> testbench/fasu_unit_asserts.sv
// Port-level checks of the float/fixed add-subtract datapath
`timescale 1ns/1ps
module fasu_unit_asserts (
    input logic core_clk,
    input logic arst_n,
    input logic clk_en,
    input logic overflow_saturate_enable,
    input fasu_pkg::fasu_alu_req_t alu_req,
    input fasu_pkg::fasu_mul_req_t mul_req,
    input fasu_pkg::fasu_word_t acc_a,
    input fasu_pkg::fasu_word_t acc_b,
    input fasu_pkg::fasu_flags_t condition_flags,
    input fasu_pkg::fasu_word_t mul_out
);
    import fasu_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    // Two positive mantissas whose sum reaches the sign bit
    wire logic [16:0] fx_sum = alu_req.opa.mant + alu_req.opb.mant;
    wire logic pos_ovf = !alu_req.opa.mant[15] && !alu_req.opb.mant[15] && fx_sum[15];
    wire logic take = clk_en && alu_req.go;
    wire logic add_a = take && !alu_req.dst && alu_req.op == FASU_OP_ADD;
    acc_a_hold_a: assert property (
        !(take && !alu_req.dst) |=> $stable(acc_a)) else $error("acc_a changed with no write");
    acc_b_hold_a: assert property (
        !(take && alu_req.dst) |=> $stable(acc_b)) else $error("acc_b changed with no write");
    flag_hold_a: assert property (
        !take |=> $stable(condition_flags)) else $error("flags changed with no operation");
    zero_flag_a: assert property (
        take |=> condition_flags.zero == (($past(alu_req.dst) ? acc_b.mant : acc_a.mant) == 16'h0000))
        else $error("zero flag disagrees with result");
    neg_flag_a: assert property (
        take |=> condition_flags.neg == ($past(alu_req.dst) ? acc_b.mant[15] : acc_a.mant[15]))
        else $error("negative flag disagrees with result");
    fixed_expo_a: assert property (
        take && !alu_req.dst && (alu_req.op == FASU_OP_FLT2FIX || (!alu_req.flt && alu_req.op != FASU_OP_FIX2FLT))
        |=> acc_a.expo == 4'h0) else $error("fixed result exponent not zero");
    fixed_sat_a: assert property (
        add_a && !alu_req.flt && !alu_req.uns && overflow_saturate_enable && pos_ovf
        |=> acc_a.mant == FASU_MANT_POS) else $error("fixed overflow not saturated");
    float_ovf_a: assert property (
        add_a && alu_req.flt && alu_req.opa.expo == 4'h7 && alu_req.opb.expo == 4'h7 && pos_ovf
        |=> acc_a == {FASU_MANT_POS, 4'h7}) else $error("float overflow not clamped");
    mul_expo_a: assert property (
        clk_en && mul_req.go && !mul_req.flt |=> mul_out.expo == 4'h0) else $error("fixed product exponent not zero");
endmodule

// >>> testbench/fasu_dec_model.sv
// Decoder stand-in that presents one instruction per cycle
`timescale 1ns/1ps
module fasu_dec_model (
    input logic core_clk,
    output fasu_pkg::fasu_alu_req_t alu_req,
    output fasu_pkg::fasu_mul_req_t mul_req
);
    import fasu_pkg::*;
    initial begin
        alu_req = '0;
        mul_req = '0;
    end
    // Mode bits travel with every instruction, never left from the last one
    task automatic issue(fasu_alu_req_t r, fasu_mul_req_t m);
        @(posedge core_clk);
        alu_req <= r;
        mul_req <= m;
    endtask
endmodule

// >>> testbench/fasu_unit_tb_top.sv
// Self-checking bench of the float/fixed add-subtract datapath
`timescale 1ns/1ps
module fasu_unit_tb_top;
    import fasu_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic ose = 1'b0;
    fasu_alu_req_t alu_req;
    fasu_mul_req_t mul_req;
    fasu_word_t acc_a, acc_b, mul_out, want_w;
    fasu_flags_t condition_flags, want_f;
    logic want_dst;
    int err_count = 0;
    int checks_done = 0;
    int p, e;
    logic [63:0] rnd;

    always #2 core_clk = ~core_clk;

    fasu_dec_model dec (.core_clk(core_clk), .alu_req(alu_req), .mul_req(mul_req));
    fasu_unit uut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .overflow_saturate_enable(ose),
        .alu_req(alu_req), .mul_req(mul_req), .acc_a(acc_a), .acc_b(acc_b),
        .condition_flags(condition_flags), .mul_out(mul_out));

    task automatic check(string what, logic [19:0] seen, logic [19:0] want);
        checks_done++;
        if (seen !== want) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Left normalize, stopping at the bottom exponent so small values stay fixed point
    function automatic fasu_word_t norm(int s, int e);
        while (s > -16385 && s < 16384 && s != 0 && e > -8) begin
            s = s * 2;
            e--;
        end
        if (s == 0) e = -8;
        if (e > 7) return {(s < 0) ? FASU_MANT_NEG : FASU_MANT_POS, 4'h7};
        return {s[15:0], e[3:0]};
    endfunction

    function automatic void ref_op(fasu_alu_req_t r, logic os, output fasu_word_t w, output fasu_flags_t f);
        int ea = $signed(r.opa.expo);
        int eb = $signed(r.opb.expo);
        int sc = $signed(r.opb.mant[3:0]);
        logic sub = (r.op == FASU_OP_SUB);
        logic [15:0] xa = r.opa.mant;
        logic [15:0] xb = sub ? ~r.opb.mant : r.opb.mant;
        logic cin = sub;
        logic [16:0] u;
        int s;
        int em;
        f = '0;
        if (r.op == FASU_OP_FLT2FIX) begin
            s = (sc >= ea) ? $signed(xa) >>> ((sc - ea > 15) ? 15 : sc - ea) : $signed(xa) <<< (ea - sc);
            if (s > 32767 || s < -32768) s = xa[15] ? -32768 : 32767;
            w = {s[15:0], 4'h0};
        end else if (r.op == FASU_OP_FIX2FLT) begin
            w = norm($signed(xa), sc);
        end else if (!r.flt) begin
            u = xa + xb + cin;
            w = {u[15:0], 4'h0};
            f.carry = u[16];
            if (os && r.uns && (u[16] ^ sub)) w.mant = sub ? FASU_UNS_MIN : FASU_UNS_MAX;
            if (os && !r.uns && xa[15] == xb[15] && u[15] != xa[15]) w.mant = xa[15] ? FASU_MANT_NEG : FASU_MANT_POS;
        end else begin
            if (ea >= eb) xb = $signed(xb) >>> ((ea - eb > 15) ? 15 : ea - eb);
            else xa = $signed(xa) >>> ((eb - ea > 15) ? 15 : eb - ea);
            cin = sub && ea <= eb;
            u = xa + xb + cin;
            f.carry = u[16];
            s = $signed(xa) + $signed(xb) + int'(cin);
            em = (ea > eb) ? ea : eb;
            w = (s > 32767 || s < -32768) ? norm(s >>> 1, em + 1) : norm(s, em);
        end
        f.neg = w.mant[15];
        f.zero = (w.mant == 16'h0000);
    endfunction

    // Adder results land just after the same edge that takes the request
    always @(posedge core_clk) begin
        if (arst_n && clk_en && alu_req.go) begin
            ref_op(alu_req, ose, want_w, want_f);
            want_dst = alu_req.dst;
            #1;
            check("acc", want_dst ? acc_b : acc_a, want_w);
            check("flags", {17'h0_0000, condition_flags}, {17'h0_0000, want_f});
        end
    end

    // Product keeps bits 22 down to 7; exponent sums clamp to the legal span
    always @(posedge core_clk) begin
        if (arst_n && clk_en && mul_req.go) begin
            p = $signed(mul_req.x) * $signed(mul_req.y);
            e = $signed(mul_req.ex) + $signed(mul_req.ey);
            e = !mul_req.flt ? 0 : (e > 7 ? 7 : (e < -8 ? -8 : e));
            #1;
            check("mul", mul_out, {p[22:7], e[3:0]});
        end
    end

    task automatic run(logic [1:0] op, logic flt, logic [19:0] a, logic [19:0] b);
        dec.issue({1'b1, op, flt, 2'b00, a, b}, '0);
    endtask

    initial begin
        void'($urandom(32'he885));
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        ose <= 1'b1;
        run(2'h0, 1'b1, 20'h7fff_7, 20'h7fff_7);
        run(2'h0, 1'b1, 20'h0001_8, 20'h0001_8);
        run(2'h0, 1'b0, 20'h7fff_0, 20'h0001_0);
        run(2'h2, 1'b0, 20'h4000_7, 20'h0008_0);
        run(2'h2, 1'b0, 20'h8000_0, 20'h0007_0);
        run(2'h3, 1'b0, 20'h0003_0, 20'h0002_0);
        run(2'h1, 1'b1, 20'h4000_3, 20'h4000_3);
        run(2'h1, 1'b1, 20'h4000_5, 20'h4000_1);
        run(2'h0, 1'b1, 20'h4000_7, 20'hc000_8);
        // Random traffic, with enable gaps and idle cycles mixed in
        repeat (400) begin
            rnd = {$urandom(), $urandom()};
            dec.issue(rnd[45:0], {rnd[62:46], rnd[16:0]});
            clk_en <= ($urandom_range(7) != 0);
            ose <= rnd[63];
        end
        dec.issue('0, '0);
        clk_en <= 1'b1;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b0;
        @(posedge core_clk);
        #1;
        check("reset", acc_a | acc_b | mul_out, 20'h0_0000);
        check("reset flags", {17'h0_0000, condition_flags}, 20'h0_0000);
        @(posedge core_clk);
        arst_n <= 1'b1;
        run(2'h0, 1'b1, 20'h0001_8, 20'h0001_8);
        dec.issue('0, '0);
        repeat (3) @(posedge core_clk);
        close_out();
    end

    // Hang guard well beyond the expected run length
    initial begin
        #20000;
        err_count++;
        close_out();
    end
endmodule

bind fasu_unit fasu_unit_asserts u_chk (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .overflow_saturate_enable(overflow_saturate_enable),
    .alu_req(alu_req),
    .mul_req(mul_req),
    .acc_a(acc_a),
    .acc_b(acc_b),
    .condition_flags(condition_flags),
    .mul_out(mul_out)
);
